// [logic/atmr_defs.svh]
`ifndef ATMR_DEFS_SVH
`define ATMR_DEFS_SVH
// register byte offsets
`define ATMR_OFF_CTRL 8'h00
`define ATMR_OFF_CNT 8'h04
`define ATMR_OFF_STS 8'h08
`define ATMR_OFF_SCLR 8'h0c
`define ATMR_OFF_IEN 8'h10
`define ATMR_OFF_IDIS 8'h14
`define ATMR_OFF_IMSK 8'h18
`define ATMR_OFF_WAKE 8'h1c
`define ATMR_OFF_MATCH0 8'h20
`define ATMR_OFF_MATCH1 8'h24
`define ATMR_OFF_TAP0 8'h30
`define ATMR_OFF_TAP1 8'h34
`define ATMR_OFF_CLKC 8'h40
`define ATMR_OFF_TUNE 8'h44
`define ATMR_OFF_EVEN 8'h48
`define ATMR_OFF_EVDIS 8'h4c
`define ATMR_OFF_EVMSK 8'h50
`define ATMR_OFF_DTIME 8'h54
`define ATMR_OFF_BUILD 8'hf0
`define ATMR_OFF_REV 8'hfc
// control fields
`define ATMR_CTRL_EN 0
`define ATMR_CTRL_CLRDIV 1
`define ATMR_CTRL_CAL 2
`define ATMR_CTRL_CA0 8
`define ATMR_CTRL_PSEL_LO 16
`define ATMR_CTRL_MASK 32'h001f_0305
// status bit positions
`define ATMR_ST_WRAP 0
`define ATMR_ST_MATCH0 8
`define ATMR_ST_PER0 16
`define ATMR_ST_BUSY 24
`define ATMR_ST_READY 25
`define ATMR_EV_MASK 32'h0003_0301
`define ATMR_IMR_MASK 32'h2203_0301
`define ATMR_SCLR_MASK 32'h2203_0301
// tuner fields
`define ATMR_TUNE_EXP_LO 0
`define ATMR_TUNE_ADD 5
`define ATMR_TUNE_VAL_LO 8
`define ATMR_TUNE_MASK 32'h0000_ff3f
`define ATMR_TUNE_FULL 10'd256
`define ATMR_TAP_MASK 32'h0000_001f
// reset values and timing
`define ATMR_RST_WORD 32'h0000_0000
`define ATMR_SYNC_CYC 3
`define ATMR_SYNC_MAX 32
`endif

// [logic/atmr_pkg.sv]
package atmr_pkg;
  // one register bus request
  typedef struct packed {
    logic [7:0] addr;
    logic [31:0] wdata;
    logic wr;
    logic rd;
  } atmr_bus_t;
  // one bit per event source
  typedef struct packed {
    logic ready;
    logic per1;
    logic per0;
    logic match1;
    logic match0;
    logic wrap;
  } atmr_src_t;
endpackage

// [logic/atmr_top.sv]
// Decided for this implementation: the address-and-strobe port.
`timescale 1ns/1ns
`default_nettype none
`include "atmr_defs.svh"

// What this block does
// - periodic request n on rise of tapped prescaler bit when enabled, masked
// - periodic flag n set on every 0-to-1 of its tapped prescaler bit
// - new tap select used only after sync; earlier rise is missed
// - match request n when counter equals match value n, masked
// - match flag n set on reaching match value, mask ignored
// - new match value used only after sync; earlier pass is missed
// - clear-on-match bits 8/9 clear counter and set wrap flag
// - wrap, periodic and match events pulse only when event mask allows
// - event enable sets mask bits, event disable clears, zeros ignored
// - wake raised on enabled wrap, match or periodic, irq mask ignored
// - wake stays until its status clear bit is written one
// - counting and wake sources keep running through shutdown
// - shutdown wake resets only the interrupt mask
// - counter and status flags kept across shutdown
// - tuner drops or inserts prescaler pulses per formula and direction
// - tuner value zero means no correction
// - synced writes set busy; writes discarded, reads zero while busy
// - sync busy period always happens, whatever the clock source
// - control bit 1 clears prescaler on one, always reads zero
// - control bit 2 is stored but drives no logic, bit 0 enables
// - count value holds full 32-bit count, readable and loadable
// - counter counts on rise of prescaler bit picked by control bits 16-20, wraps past all-ones, sets wrap flag
// - status clear one clears flag and its request, except ready, which the clear's own sync sets again; zero ignored
// - requests gated by mask; irq enable sets, irq disable clears
module atmr_top
  import atmr_pkg::*;
#(
  parameter int SYNC_CYC = `ATMR_SYNC_CYC,
  parameter logic [31:0] BUILD_OPT = 32'h0000_0000, // arbitrary value
  parameter logic [31:0] REVISION = 32'h0000_0001 // arbitrary value
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  input wire logic prsc_tick,
  input wire logic shutdown_wake,
  input wire atmr_bus_t bus,
  output logic [31:0] rdata,
  output atmr_src_t irq_req,
  output atmr_src_t events,
  output logic wake
);

  if (SYNC_CYC < 1 || SYNC_CYC > `ATMR_SYNC_MAX) begin : g_chk
    $error("SYNC_CYC out of range");
  end

  logic [31:0] ctrl_r, cnt_r, sts_r, imr_r, wer_r, clkc_r, tune_r, evm_r;
  logic [31:0] match_r [2];
  logic [4:0] tap_r [2];
  logic [31:0] presc_r, tun_cnt_r, wk_r, evt_r, rdata_r;
  logic [7:0] pend_addr_r;
  logic [31:0] pend_data_r;
  logic [5:0] sync_cnt_r;
  logic busy_r;

  // bus decode
  wire logic [7:0] a = bus.addr;
  wire logic sync_hit = a == `ATMR_OFF_CTRL || a == `ATMR_OFF_CNT ||
    a == `ATMR_OFF_SCLR || a == `ATMR_OFF_WAKE ||
    a == `ATMR_OFF_MATCH0 || a == `ATMR_OFF_MATCH1 ||
    a == `ATMR_OFF_TAP0 || a == `ATMR_OFF_TAP1 ||
    a == `ATMR_OFF_TUNE || a == `ATMR_OFF_EVEN ||
    a == `ATMR_OFF_EVDIS || a == `ATMR_OFF_DTIME;
  wire logic accept = bus.wr && sync_hit && !busy_r;
  wire logic apply = busy_r && sync_cnt_r == 6'd1;
  wire logic ap_ctrl = apply && pend_addr_r == `ATMR_OFF_CTRL;
  wire logic ap_cnt = apply && (pend_addr_r == `ATMR_OFF_CNT ||
    pend_addr_r == `ATMR_OFF_DTIME);
  wire logic ap_sclr = apply && pend_addr_r == `ATMR_OFF_SCLR;
  wire logic ap_even = apply && pend_addr_r == `ATMR_OFF_EVEN;
  wire logic ap_evdis = apply && pend_addr_r == `ATMR_OFF_EVDIS;
  wire logic ien_w = bus.wr && a == `ATMR_OFF_IEN;
  wire logic idis_w = bus.wr && a == `ATMR_OFF_IDIS;

  // control fields
  wire logic en = ctrl_r[`ATMR_CTRL_EN];
  wire logic [1:0] ca = ctrl_r[`ATMR_CTRL_CA0 +: 2];
  wire logic [4:0] psel = ctrl_r[`ATMR_CTRL_PSEL_LO +: 5];
  wire logic clr_div = ap_ctrl && pend_data_r[`ATMR_CTRL_CLRDIV];

  // tuner: pulse period from value and exponent
  wire logic [7:0] tun_val = tune_r[`ATMR_TUNE_VAL_LO +: 8];
  wire logic [4:0] tun_exp = tune_r[`ATMR_TUNE_EXP_LO +: 5];
  wire logic tun_add = tune_r[`ATMR_TUNE_ADD];
  wire logic [9:0] tun_div = tun_val == 8'h00 ? 10'd1 : {2'b00, tun_val};
  wire logic [9:0] tun_up = 10'((`ATMR_TUNE_FULL + tun_div - 10'd1) /
    tun_div);
  wire logic [31:0] tun_n = {22'h0, tun_up} << tun_exp;
  // reduce: one pulse lost per n+1; raise: one extra per n-1
  wire logic [31:0] tun_len = tun_add ? tun_n - 32'd1 : tun_n + 32'd1;
  wire logic tick = prsc_tick && en;
  wire logic tun_on = tun_val != 8'h00;
  wire logic tun_hit = tick && tun_on && tun_cnt_r >= tun_len - 32'd1;
  wire logic [31:0] step = !tun_hit ? 32'd1 :
    (tun_add ? 32'd2 : 32'd0);
  wire logic [31:0] presc_nxt = presc_r + step;
  wire logic [31:0] rise = tick ? (~presc_r & presc_nxt) : 32'h0;

  // counter stepping
  wire logic cnt_tick = rise[psel];
  wire logic [31:0] cnt_inc = cnt_r + 32'd1;
  wire logic roll = cnt_tick && cnt_r == 32'hffff_ffff;
  logic [1:0] per_hit, match_hit;

  // per channel periodic and match detection
  for (genvar n = 0; n < 2; n++) begin : g_ch
    assign per_hit[n] = rise[tap_r[n]];
    assign match_hit[n] = cnt_tick && cnt_inc == match_r[n];
  end

  wire logic ca_clr = |(match_hit & ca);
  wire logic wrap_ev = roll || ca_clr;
  wire logic [31:0] ev_bits = {14'h0, per_hit, 6'h0, match_hit, 7'h0,
    wrap_ev};
  wire logic [31:0] set_bits = ev_bits | ({31'h0, apply} << `ATMR_ST_READY);
  wire logic [31:0] clr_bits = ap_sclr ?
    (pend_data_r & `ATMR_SCLR_MASK) : 32'h0;
  // set wins over a clear landing in the same cycle
  wire logic [31:0] sts_nxt = (sts_r & ~clr_bits) | set_bits;
  wire logic [31:0] wk_nxt = (wk_r & ~clr_bits) |
    (ev_bits & wer_r);
  wire logic [31:0] cnt_nxt = ap_cnt ? pend_data_r :
    ca_clr ? 32'h0 : cnt_tick ? cnt_inc : cnt_r;
  wire logic [31:0] imr_nxt = shutdown_wake ? 32'h0 :
    ((imr_r | (ien_w ? bus.wdata : 32'h0)) &
    ~(idis_w ? bus.wdata : 32'h0)) & `ATMR_IMR_MASK;
  wire logic [31:0] evm_nxt = ((evm_r | (ap_even ? pend_data_r : 32'h0)) &
    ~(ap_evdis ? pend_data_r : 32'h0)) & `ATMR_EV_MASK;

  // read mux; synced registers read zero while busy
  wire logic rd_zero = busy_r && sync_hit;
  logic [31:0] rd_mux;
  always_comb begin
    case (a)
      `ATMR_OFF_CTRL: rd_mux = ctrl_r;
      `ATMR_OFF_CNT: rd_mux = cnt_r;
      `ATMR_OFF_STS: rd_mux = sts_r | ({31'h0, busy_r} << `ATMR_ST_BUSY);
      `ATMR_OFF_IMSK: rd_mux = imr_r;
      `ATMR_OFF_WAKE: rd_mux = wer_r;
      `ATMR_OFF_MATCH0: rd_mux = match_r[0];
      `ATMR_OFF_MATCH1: rd_mux = match_r[1];
      `ATMR_OFF_TAP0: rd_mux = {27'h0, tap_r[0]};
      `ATMR_OFF_TAP1: rd_mux = {27'h0, tap_r[1]};
      `ATMR_OFF_CLKC: rd_mux = clkc_r;
      `ATMR_OFF_TUNE: rd_mux = tune_r;
      `ATMR_OFF_EVMSK: rd_mux = evm_r;
      `ATMR_OFF_DTIME: rd_mux = cnt_r;
      `ATMR_OFF_BUILD: rd_mux = BUILD_OPT;
      `ATMR_OFF_REV: rd_mux = REVISION;
      default: rd_mux = 32'h0;
    endcase
  end

  // write sync: capture once, apply after SYNC_CYC cycles
  always_ff @(posedge clk) begin
    if (rst) begin
      pend_addr_r <= 8'h0;
      pend_data_r <= `ATMR_RST_WORD;
      sync_cnt_r <= 6'd0;
      busy_r <= 1'b0;
    end else if (ce) begin
      if (accept) begin
        pend_addr_r <= a;
        pend_data_r <= bus.wdata;
        sync_cnt_r <= 6'(SYNC_CYC);
        busy_r <= 1'b1;
      end else if (busy_r) begin
        sync_cnt_r <= sync_cnt_r - 6'd1;
        busy_r <= sync_cnt_r != 6'd1;
      end
    end
  end

  // synced configuration registers
  always_ff @(posedge clk) begin
    if (rst) begin
      ctrl_r <= `ATMR_RST_WORD;
      wer_r <= `ATMR_RST_WORD;
      tune_r <= `ATMR_RST_WORD;
      match_r[0] <= `ATMR_RST_WORD;
      match_r[1] <= `ATMR_RST_WORD;
      tap_r[0] <= 5'h0;
      tap_r[1] <= 5'h0;
    end else if (ce && apply) begin
      case (pend_addr_r)
        `ATMR_OFF_CTRL: ctrl_r <= pend_data_r & `ATMR_CTRL_MASK;
        `ATMR_OFF_WAKE: wer_r <= pend_data_r & `ATMR_EV_MASK;
        `ATMR_OFF_TUNE: tune_r <= pend_data_r & `ATMR_TUNE_MASK;
        `ATMR_OFF_MATCH0: match_r[0] <= pend_data_r;
        `ATMR_OFF_MATCH1: match_r[1] <= pend_data_r;
        `ATMR_OFF_TAP0: tap_r[0] <= pend_data_r[4:0];
        `ATMR_OFF_TAP1: tap_r[1] <= pend_data_r[4:0];
        default: ;
      endcase
    end
  end

  // counting core; keeps running while the system is shut down
  always_ff @(posedge clk) begin
    if (rst) begin
      presc_r <= `ATMR_RST_WORD;
      tun_cnt_r <= `ATMR_RST_WORD;
      cnt_r <= `ATMR_RST_WORD;
    end else if (ce) begin
      presc_r <= clr_div ? 32'h0 : (tick ? presc_nxt : presc_r);
      tun_cnt_r <= (clr_div || tun_hit || !tun_on) ? 32'h0 :
        (tick ? tun_cnt_r + 32'd1 : tun_cnt_r);
      cnt_r <= cnt_nxt;
    end
  end

  // status, masks, wake and event pulses
  always_ff @(posedge clk) begin
    if (rst) begin
      sts_r <= `ATMR_RST_WORD;
      wk_r <= `ATMR_RST_WORD;
      imr_r <= `ATMR_RST_WORD;
      evm_r <= `ATMR_RST_WORD;
      evt_r <= `ATMR_RST_WORD;
      clkc_r <= `ATMR_RST_WORD;
      rdata_r <= `ATMR_RST_WORD;
    end else if (ce) begin
      sts_r <= sts_nxt;
      wk_r <= wk_nxt;
      imr_r <= imr_nxt;
      evm_r <= evm_nxt;
      evt_r <= ev_bits & evm_r;
      if (bus.wr && a == `ATMR_OFF_CLKC) begin
        clkc_r <= bus.wdata;
      end
      rdata_r <= (bus.rd && !rd_zero) ? rd_mux : 32'h0;
    end
  end

  // requests follow flags through the mask
  wire logic [31:0] req_bits = sts_r & imr_r;
  assign irq_req = '{ready: req_bits[`ATMR_ST_READY],
    per1: req_bits[17], per0: req_bits[16], match1: req_bits[9],
    match0: req_bits[8], wrap: req_bits[0]};
  assign events = '{ready: 1'b0, per1: evt_r[17], per0: evt_r[16],
    match1: evt_r[9], match0: evt_r[8], wrap: evt_r[0]};
  assign wake = |wk_r;
  assign rdata = rdata_r;

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  a_per_flag_set: assert property (ce && per_hit[0] |=> sts_r[16])
    else $error("periodic flag not set");
  a_match_flag: assert property (ce && match_hit[1] |=> sts_r[9])
    else $error("match flag not set");
  a_match_clears: assert property (ce && ca_clr && !ap_cnt |=>
    cnt_r == 32'h0 && sts_r[0])
    else $error("clear on match failed");
  a_wrap_roll: assert property (ce && roll && !ap_cnt |=>
    cnt_r == 32'h0 && sts_r[0])
    else $error("wrap did not roll");
  a_busy_read_zero: assert property (bus.rd && busy_r && sync_hit
    |=> rdata == 32'h0)
    else $error("busy read not zero");
  a_sync_ends: assert property (ce && accept |=>
    busy_r ##[0:40] !busy_r)
    else $error("sync never completed");
  a_clrdiv_reads: assert property (bus.rd && a == `ATMR_OFF_CTRL
    |=> !rdata[1])
    else $error("prescaler clear bit read one");
  a_wake_holds: assert property (ce && wake && !ap_sclr |=> wake)
    else $error("wake dropped without clear");
  a_shut_imr: assert property (ce && shutdown_wake |=>
    imr_r == 32'h0 && $stable(ctrl_r))
    else $error("shutdown wake mask wrong");
  a_event_gate: assert property ((evt_r & ~$past(evm_r)) == 32'h0)
    else $error("event emitted while masked");
  a_irq_gate: assert property ((req_bits & ~imr_r) == 32'h0)
    else $error("request without mask");
  a_tuner_off: assert property (!tun_on |-> !tun_hit)
    else $error("tuner active at zero");

  c_periodic: cover property (ce && per_hit[0] && evm_r[16]);
  c_match_clear: cover property (ce && ca_clr);
  c_wake_clear: cover property (wake ##1 ap_sclr ##1 !wake);
  c_busy_drop: cover property (busy_r && bus.wr && sync_hit);

endmodule
`default_nettype wire

// [bench/atmr_far_model.sv]
`timescale 1ns/1ns
`default_nettype none
module atmr_far_model
  import atmr_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire atmr_src_t events,
  input wire logic sd_req,
  output logic shutdown_wake,
  output logic [15:0] wrap_ev,
  output logic [15:0] per1_ev
);
  logic sd_q_r;
  // event system side: count pulses, each pulse is one cycle wide
  always_ff @(posedge clk) begin
    if (rst) begin
      wrap_ev <= 16'h0000;
      per1_ev <= 16'h0000;
    end else begin
      wrap_ev <= wrap_ev + 16'(events.wrap);
      per1_ev <= per1_ev + 16'(events.per1);
    end
  end
  // sleep controller: one wake-from-shutdown pulse per request edge
  always_ff @(posedge clk) begin
    sd_q_r <= sd_req & ~rst;
    shutdown_wake <= sd_req & ~sd_q_r & ~rst;
  end
endmodule
`default_nettype wire

// [bench/tb_async_timer_alarm_wake_sync.sv]
`timescale 1ns/1ns
`default_nettype none
`include "atmr_defs.svh"
module tb_async_timer_alarm_wake_sync;
  import atmr_pkg::*;
  localparam logic [31:0] BOPT = 32'h0000_00a5; // arbitrary value
  localparam logic [31:0] REV = 32'h0000_0003; // arbitrary value
  localparam logic [31:0] FLG = `ATMR_EV_MASK;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic ce = 1'b1;
  logic prsc_tick = 1'b0;
  logic sd_req = 1'b0;
  logic run_en = 1'b0;
  logic shutdown_wake;
  atmr_bus_t bus_q = '0;
  logic [31:0] rdata;
  atmr_src_t irq_req;
  atmr_src_t events;
  logic wake;
  logic [15:0] wrap_ev;
  logic [15:0] per1_ev;
  int n_errors = 0;
  int cmp_count = 0;
  logic [31:0] v;
  logic [31:0] w;
  logic [31:0] d;
  logic [7:0] ra [6] = '{8'h20, 8'h24, 8'h30, 8'h34, 8'h44, 8'h1c};
  logic [31:0] rm [6] = '{32'hffff_ffff, 32'hffff_ffff, `ATMR_TAP_MASK,
    `ATMR_TAP_MASK, `ATMR_TUNE_MASK, FLG};

  always #10 clk = ~clk;
  // random source-clock edges while the run gate is open
  always @(posedge clk) prsc_tick <= run_en & ($urandom_range(1, 0) != 0);

  atmr_top #(.SYNC_CYC(6), .BUILD_OPT(BOPT), .REVISION(REV)) i_atmr_top (
    .clk(clk), .rst(rst), .ce(ce), .prsc_tick(prsc_tick),
    .shutdown_wake(shutdown_wake), .bus(bus_q), .rdata(rdata),
    .irq_req(irq_req), .events(events), .wake(wake));
  atmr_far_model i_atmr_far_model (
    .clk(clk), .rst(rst), .events(events), .sd_req(sd_req),
    .shutdown_wake(shutdown_wake), .wrap_ev(wrap_ev), .per1_ev(per1_ev));

  task automatic stop_test();
    if (n_errors == 0 && cmp_count > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      n_errors++;
      $display("[ERR] %0t seen %h exp %h", $time, seen, exp);
    end
  endtask
  // bus cycles start right after an edge; a gap cycle avoids strobe reuse
  task automatic wr(input logic [7:0] a, input logic [31:0] dat);
    bus_q.addr <= a;
    bus_q.wdata <= dat;
    bus_q.wr <= 1'b1;
    @(posedge clk);
    bus_q.wr <= 1'b0;
    @(posedge clk);
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] dat);
    bus_q.addr <= a;
    bus_q.rd <= 1'b1;
    @(posedge clk);
    bus_q.rd <= 1'b0;
    #1 dat = rdata;
    @(posedge clk);
  endtask
  task automatic rdchk(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] x;
    rd(a, x);
    chk(x, e);
  endtask
  // poll busy with a bound; a stuck busy shows as a mismatch
  task automatic sync_wait();
    logic [31:0] s;
    for (int i = 0; i < 40; i++) begin
      rd(`ATMR_OFF_STS, s);
      if (s[`ATMR_ST_BUSY] === 1'b0)
        break;
    end
    chk(32'(s[`ATMR_ST_BUSY]), 32'h0);
  endtask
  task automatic wrs(input logic [7:0] a, input logic [31:0] dat);
    wr(a, dat);
    sync_wait();
  endtask
  // let the prescaler run until a status bit shows, then freeze it
  task automatic wait_sts(input int b);
    logic [31:0] s;
    run_en = 1'b1;
    for (int i = 0; i < 600; i++) begin
      rd(`ATMR_OFF_STS, s);
      if (s[b] === 1'b1)
        break;
    end
    run_en = 1'b0;
    chk(32'(s[b]), 32'h1);
    repeat (2) @(posedge clk);
  endtask

  initial begin
    repeat (20000) @(posedge clk);
    n_errors++;
    stop_test();
  end

  initial begin
    v = $urandom(32'h511b);
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    // reset values, unmapped holes included
    for (int a = 0; a < 96; a += 4)
      rdchk(8'(a), 32'h0);
    rdchk(8'hf0, BOPT);
    rdchk(8'hfc, REV);
    chk(32'(wake), 32'h0);
    // plain storage with random data, masked to the implemented bits
    for (int i = 0; i < 6; i++) begin
      v = $urandom;
      wrs(ra[i], v);
      rdchk(ra[i], v & rm[i]);
    end
    v = $urandom;
    wrs(`ATMR_OFF_CNT, v);
    rdchk(`ATMR_OFF_CNT, v);
    v = $urandom | 32'h2;
    wrs(`ATMR_OFF_CTRL, v);
    rdchk(`ATMR_OFF_CTRL, v & `ATMR_CTRL_MASK & ~32'h2);
    wrs(`ATMR_OFF_CTRL, 32'h0);
    // writes and reads during busy
    wrs(`ATMR_OFF_MATCH0, 32'h0000_0100);
    wr(`ATMR_OFF_TAP0, 32'h0000_0003);
    wr(`ATMR_OFF_MATCH0, 32'h0000_0777);
    rdchk(`ATMR_OFF_MATCH0, 32'h0);
    sync_wait();
    rdchk(`ATMR_OFF_MATCH0, 32'h0000_0100);
    rd(`ATMR_OFF_STS, d);
    chk(d & 32'h0200_0000, 32'h0200_0000);
    // set-only and clear-only mask registers
    v = $urandom;
    w = $urandom;
    wr(`ATMR_OFF_IEN, v);
    rdchk(`ATMR_OFF_IMSK, v & `ATMR_IMR_MASK);
    wr(`ATMR_OFF_IDIS, w);
    rdchk(`ATMR_OFF_IMSK, v & ~w & `ATMR_IMR_MASK);
    wrs(`ATMR_OFF_EVEN, v);
    rdchk(`ATMR_OFF_EVMSK, v & FLG);
    wrs(`ATMR_OFF_EVDIS, w);
    rdchk(`ATMR_OFF_EVMSK, v & ~w & FLG);
    wr(`ATMR_OFF_IDIS, 32'hffff_ffff);
    wrs(`ATMR_OFF_EVDIS, 32'hffff_ffff);
    wrs(`ATMR_OFF_EVEN, 32'h0000_0001);
    wrs(`ATMR_OFF_WAKE, 32'h0);
    wrs(`ATMR_OFF_SCLR, 32'hffff_ffff);
    // wrap past all-ones
    wrs(`ATMR_OFF_MATCH1, 32'hffff_0000);
    wrs(`ATMR_OFF_CNT, 32'hffff_fff8);
    wrs(`ATMR_OFF_CTRL, 32'h0000_0001);
    wait_sts(`ATMR_ST_WRAP);
    wrs(`ATMR_OFF_CTRL, 32'h0);
    // periodic flags also rise while enabled, so look at wrap and match only
    rd(`ATMR_OFF_STS, d);
    chk(d & 32'h0000_0301, 32'h0000_0001);
    rd(`ATMR_OFF_CNT, d);
    chk(32'(d < 32'h20), 32'h1);
    chk(32'(wrap_ev != 16'h0), 32'h1);
    wrs(`ATMR_OFF_SCLR, 32'hffff_ffff);
    rd(`ATMR_OFF_STS, d);
    chk(d & FLG, 32'h0);
    // match with clear-on-match and wake on match
    wrs(`ATMR_OFF_MATCH0, 32'h0000_0005);
    wrs(`ATMR_OFF_CNT, 32'h0);
    wrs(`ATMR_OFF_WAKE, 32'h0000_0100);
    wrs(`ATMR_OFF_CTRL, 32'h0000_0101);
    wait_sts(`ATMR_ST_MATCH0);
    wrs(`ATMR_OFF_CTRL, 32'h0000_0104);
    rd(`ATMR_OFF_STS, d);
    chk(d & 32'h0000_0301, 32'h0000_0101);
    chk(32'(wake), 32'h1);
    chk(32'(irq_req.match0), 32'h0);
    wr(`ATMR_OFF_IEN, 32'h0000_0100);
    chk(32'(irq_req.match0), 32'h1);
    rd(`ATMR_OFF_CNT, d);
    chk(32'(d < 32'h5), 32'h1);
    // shutdown wake keeps all but the interrupt mask
    wrs(`ATMR_OFF_CNT, 32'h1234_5678);
    sd_req <= 1'b1;
    repeat (3) @(posedge clk);
    sd_req <= 1'b0;
    rdchk(`ATMR_OFF_IMSK, 32'h0);
    rdchk(`ATMR_OFF_CTRL, 32'h0000_0104);
    rdchk(`ATMR_OFF_CNT, 32'h1234_5678);
    rd(`ATMR_OFF_STS, d);
    chk(d & 32'h0000_0301, 32'h0000_0101);
    chk(32'(wake), 32'h1);
    // clear periodic flags too, else the periodic wait below ends at once
    wrs(`ATMR_OFF_SCLR, 32'h0003_0301);
    chk(32'(wake), 32'h0);
    // periodic flags, wake on periodic, per1 event masked off
    wrs(`ATMR_OFF_TAP0, 32'h0);
    wrs(`ATMR_OFF_TAP1, 32'h0);
    wrs(`ATMR_OFF_WAKE, 32'h0001_0000);
    wrs(`ATMR_OFF_CTRL, 32'h0000_0001);
    wait_sts(`ATMR_ST_PER0 + 1);
    wrs(`ATMR_OFF_CTRL, 32'h0);
    rd(`ATMR_OFF_STS, d);
    chk(d & 32'h0003_0000, 32'h0003_0000);
    chk(32'(wake), 32'h1);
    chk(32'(irq_req.per0), 32'h0);
    chk(32'(per1_ev), 32'h0);
    // tuner set up as software must: exponent above zero, tap 6 or more
    wrs(`ATMR_OFF_TUNE, 32'h0000_8021);
    rdchk(`ATMR_OFF_TUNE, 32'h0000_8021);
    wrs(`ATMR_OFF_TAP0, 32'h0000_0006);
    rdchk(`ATMR_OFF_TAP0, 32'h0000_0006);
    stop_test();
  end
endmodule
`default_nettype wire
